//--- hdl/wake_crc_lane.v
/*
 Holds one filter lane: it keeps a running CRC-16 over the frame bytes selected by the
 lane's offset and byte mask and reports a match at the end of a frame.
 Assumes frame bytes arrive one per clock with a start strobe on the first byte.
*/
`timescale 1ns/1ps
`include "wake_filter_map.vh"

module wake_crc_lane #(
	parameter MASK_W = 31
) (
	// Clock and reset
	input  wire              clock,
	input  wire              rst,
	// Filter configuration
	input  wire [MASK_W-1:0] byte_mask,
	input  wire [7:0]        pattern_offset,
	input  wire [15:0]       pattern_crc,
	input  wire              filter_enable,
	input  wire              want_multicast,
	// Frame stream
	input  wire              frame_start,
	input  wire              byte_valid,
	input  wire [7:0]        byte_data,
	input  wire [10:0]       byte_index,
	input  wire              is_multicast,
	input  wire              frame_end,
	// Result
	output reg               match_r
);

	reg  [15:0] crc_r;
	reg  [15:0] crc_nxt;
	reg         type_ok_r;
	wire [10:0] rel;
	wire        in_window;
	wire        take;
	wire [15:0] crc_seed;
	integer     k;

	assign rel       = byte_index - {3'h0, pattern_offset};
	assign in_window = (byte_index >= {3'h0, pattern_offset}) && (rel < MASK_W);
	assign take      = byte_valid && in_window && byte_mask[rel[4:0]];
	assign crc_seed  = frame_start ? `WF_CRC_INIT : crc_r;

	// ==================================================================
	// CRC-16 over one byte, most significant bit first
	// ==================================================================
	always @* begin
		crc_nxt = crc_seed;
		for (k = 7; k >= 0; k = k - 1) begin
			if (crc_nxt[15] ^ byte_data[k])
				crc_nxt = {crc_nxt[14:0], 1'b0} ^ `WF_CRC_POLY;
			else
				crc_nxt = {crc_nxt[14:0], 1'b0};
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			crc_r     <= `WF_CRC_INIT;
			type_ok_r <= 1'b0;
			match_r   <= 1'b0;
		end else begin
			if (take)
				crc_r <= crc_nxt;
			else if (frame_start)
				crc_r <= `WF_CRC_INIT;
			if (frame_start)
				type_ok_r <= (is_multicast == want_multicast);
			match_r <= frame_end && filter_enable && type_ok_r &&
				(crc_r == pattern_crc);
		end
	end

endmodule // wake_crc_lane

//--- hdl/wake_frame_pattern_filter.v
/*
 Holds the wake-up frame pattern filter: the eight-word filter load port, four filter lanes,
 sticky wake status with mask and a level interrupt.
 Assumes a simple register port with read data one cycle after the read strobe, and a
 receive byte stream synchronous to the same clock.
*/
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "wake_filter_map.vh"

// Function
// - Mask bit j selects frame byte offset plus j for the CRC, and bit 31 of a mask is zero.
// - A set address-type bit restricts a filter to multicast frames, a clear one to unicast.
// - A filter is evaluated only while its enable bit is set.
// - The offset is the frame byte, counted from the destination address, where a filter starts.
// - The offset word holds filter 3 in its top byte down to filter 0 in its bottom byte.
// - A CRC-16 over the selected bytes equal to the stored value signals a wake-up frame.
module wake_frame_pattern_filter #(
	parameter NUM_FILTERS = `WF_NUM_FILTERS,
	parameter MASK_W      = `WF_MASK_WIDTH
) (
	// Clock and reset
	input  wire        clock,
	input  wire        rst,
	// Register port
	input  wire [7:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_write,
	input  wire        reg_read,
	output reg  [31:0] reg_rdata_r,
	// Receive byte stream
	input  wire        rx_start,
	input  wire        rx_valid,
	input  wire [7:0]  rx_data,
	input  wire        rx_end,
	input  wire        rx_multicast,
	// Wake result
	output wire        wake_frame_pulse,
	output wire        irq
);

	// ==================================================================
	// Filter word storage
	// ==================================================================
	reg  [31:0] word_r [0:`WF_WORD_COUNT-1];
	reg  [2:0]  wr_ptr_r;
	reg  [2:0]  rd_ptr_r;
	reg  [3:0]  status_r;
	reg  [3:0]  irq_mask_r;
	reg  [10:0] index_r;
	reg  [31:0] rdata_nxt;
	wire [NUM_FILTERS-1:0] lane_match;
	wire        port_wr;
	wire        port_rd;
	wire        restart;
	wire [3:0]  status_set;
	wire        status_wr;
	wire        mask_wr;
	wire        ctrl_wr;
	wire [31:0] ptr_view;
	wire [NUM_FILTERS-1:0]    filt_enable;
	wire [NUM_FILTERS-1:0]    filt_mcast;
	wire [8*NUM_FILTERS-1:0]  filt_offset;
	wire [16*NUM_FILTERS-1:0] filt_crc;
	integer     w;

	assign port_wr   = reg_write && (reg_addr == `WF_PORT_OFS);
	assign port_rd   = reg_read && (reg_addr == `WF_PORT_OFS);
	assign status_wr = reg_write && (reg_addr == `WF_STATUS_OFS);
	assign mask_wr   = reg_write && (reg_addr == `WF_MASK_OFS);
	assign ctrl_wr   = reg_write && (reg_addr == `WF_CTRL_OFS);
	assign restart   = ctrl_wr && reg_wdata[`WF_CTRL_RESET_BIT];

	// A restart rewinds both pointers without touching the stored words, so a half-done
	// load can be begun again from the first mask.
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_ptr_r <= 3'h0;
			rd_ptr_r <= 3'h0;
			for (w = 0; w < `WF_WORD_COUNT; w = w + 1)
				word_r[w] <= `WF_WORD_RESET;
		end else begin
			if (restart) begin
				wr_ptr_r <= 3'h0;
				rd_ptr_r <= 3'h0;
			end else begin
				if (port_wr) begin
					if (wr_ptr_r < 3'h4)
						word_r[wr_ptr_r] <= {1'b0, reg_wdata[`WF_MASK_MSB:0]};
					else
						word_r[wr_ptr_r] <= reg_wdata;
					wr_ptr_r <= wr_ptr_r + 3'h1;
				end
				if (port_rd)
					rd_ptr_r <= rd_ptr_r + 3'h1;
			end
		end
	end

	// ==================================================================
	// Frame byte position, zero at the first destination address byte
	// ==================================================================
	always @(posedge clock or posedge rst) begin
		if (rst)
			index_r <= 11'h000;
		else if (rx_valid)
			index_r <= (rx_start ? 11'h000 : index_r) + 11'h001;
		else if (rx_start)
			index_r <= 11'h000;
	end

	// ==================================================================
	// Frame tracking, so an end strobe counts only after a start
	// ==================================================================
	localparam [1:0] FR_IDLE = 2'b01;
	localparam [1:0] FR_BODY = 2'b10;

	reg  [1:0]  frame_state_r;
	reg  [1:0]  frame_state_nxt;
	wire        frame_end_ok;

	always @* begin
		frame_state_nxt = frame_state_r;
		case (frame_state_r)
			FR_IDLE: begin
				if (rx_start)
					frame_state_nxt = FR_BODY;
			end
			FR_BODY: begin
				if (rx_end && !rx_start)
					frame_state_nxt = FR_IDLE;
			end
			default: begin
				frame_state_nxt = FR_IDLE;
			end
		endcase
	end

	always @(posedge clock or posedge rst) begin
		if (rst)
			frame_state_r <= FR_IDLE;
		else
			frame_state_r <= frame_state_nxt;
	end

	// A stray end strobe would otherwise repeat the verdict on the last frame's CRC.
	assign frame_end_ok = rx_end && (frame_state_r == FR_BODY);

	// ==================================================================
	// Filter fields unpacked from the command, offset and CRC words
	// ==================================================================
	genvar f;
	generate
		for (f = 0; f < NUM_FILTERS; f = f + 1) begin : field
			assign filt_enable[f] = word_r[4][f*`WF_CMD_STRIDE + `WF_CMD_ENABLE_BIT];
			assign filt_mcast[f]  = word_r[4][f*`WF_CMD_STRIDE + `WF_CMD_MCAST_BIT];
			assign filt_offset[f*8 +: 8] = word_r[5][f*8 +: 8];
			assign filt_crc[f*16 +: 16]  = word_r[6 + f/2][(f%2)*16 +: 16];
		end
	endgenerate

	// ==================================================================
	// Filter lanes
	// ==================================================================
	genvar g;
	generate
		for (g = 0; g < NUM_FILTERS; g = g + 1) begin : lane
			wake_crc_lane #(
				.MASK_W(MASK_W)
			) u_lane (
				.clock          (clock),
				.rst            (rst),
				.byte_mask      (word_r[g][MASK_W-1:0]),
				.pattern_offset (filt_offset[g*8 +: 8]),
				.pattern_crc    (filt_crc[g*16 +: 16]),
				.filter_enable  (filt_enable[g]),
				.want_multicast (filt_mcast[g]),
				.frame_start    (rx_start),
				.byte_valid     (rx_valid),
				.byte_data      (rx_data),
				.byte_index     (rx_start ? 11'h000 : index_r),
				.is_multicast   (rx_multicast),
				.frame_end      (frame_end_ok),
				.match_r        (lane_match[g])
			);
		end
	endgenerate

	assign wake_frame_pulse = |lane_match;
	assign status_set       = lane_match[3:0];

	// ==================================================================
	// Sticky status, mask and interrupt
	// ==================================================================
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			status_r   <= 4'h0;
			irq_mask_r <= 4'h0;
		end else begin
			// A match in the same cycle as a clearing write wins, so no wake event is lost.
			if (status_wr)
				status_r <= (status_r & ~reg_wdata[3:0]) | status_set;
			else
				status_r <= status_r | status_set;
			if (mask_wr)
				irq_mask_r <= reg_wdata[3:0];
		end
	end

	assign irq = |(status_r & irq_mask_r);

	// Control reads show the write pointer, so software can see how far a load has got.
	assign ptr_view = {26'h0, wr_ptr_r, 3'h0};

	// ==================================================================
	// Read data, valid the cycle after the read strobe
	// ==================================================================
	always @* begin
		rdata_nxt = 32'h0000_0000;
		case (reg_addr)
			`WF_PORT_OFS:   rdata_nxt = word_r[rd_ptr_r];
			`WF_STATUS_OFS: rdata_nxt = {28'h0000000, status_r};
			`WF_MASK_OFS:   rdata_nxt = {28'h0000000, irq_mask_r};
			`WF_CTRL_OFS:   rdata_nxt = ptr_view;
			default:        rdata_nxt = 32'h0000_0000;
		endcase
	end

	always @(posedge clock or posedge rst) begin
		if (rst)
			reg_rdata_r <= 32'h0000_0000;
		else if (reg_read)
			reg_rdata_r <= rdata_nxt;
		else
			reg_rdata_r <= 32'h0000_0000;
	end

endmodule // wake_frame_pattern_filter

//--- include/wake_filter_map.vh
/*
 Holds the register offsets, field positions, reset values and counts of the wake-up frame
 pattern filter. Assumes it is included by bare name from files under hdl/.
*/
`ifndef WAKE_FILTER_MAP_VH
`define WAKE_FILTER_MAP_VH

// ==========================================================================
// Register offsets (byte addresses on the 32-bit register port)
// ==========================================================================
`define WF_PORT_OFS        8'h00
`define WF_STATUS_OFS      8'h04
`define WF_MASK_OFS        8'h08
`define WF_CTRL_OFS        8'h0c
`define WF_WORD0_OFS       8'h10

// ==========================================================================
// Field positions
// ==========================================================================
`define WF_MASK_MSB        30
`define WF_CMD_ENABLE_BIT  0
`define WF_CMD_MCAST_BIT   3
`define WF_CMD_STRIDE      8
`define WF_CTRL_RESET_BIT  0

// ==========================================================================
// Counts and reset values
// ==========================================================================
`define WF_WORD_COUNT      8
`define WF_NUM_FILTERS     4
`define WF_MASK_WIDTH      31
`define WF_CRC_INIT        16'hffff
`define WF_CRC_POLY        16'h8005
`define WF_WORD_RESET      32'h0000_0000

`endif

//--- tb/testbench.sv
/*
 Self-checking testbench of the wake-up frame pattern filter.
 Assumes the map header is on the include path.
*/
`timescale 1ns/1ps
`include "wake_filter_map.vh"
module testbench;
	logic        clock = 0, rst = 1, reg_write = 0, reg_read = 0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	wire  [31:0] reg_rdata_r;
	wire         rx_start, rx_valid, rx_end, rx_multicast, wake_frame_pulse, irq;
	wire  [7:0]  rx_data;
	integer      n_errors = 0, num_checks = 0, i;
	logic [15:0] c02, c3;
	logic [31:0] w [8];
	wake_frame_pattern_filter dut_u (.clock(clock), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata_r(reg_rdata_r), .rx_start(rx_start), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_end(rx_end), .rx_multicast(rx_multicast),
		.wake_frame_pulse(wake_frame_pulse), .irq(irq));
	wake_frame_source src_u (.clock(clock), .rx_start(rx_start), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_end(rx_end), .rx_multicast(rx_multicast));
	initial forever #2 clock = ~clock;
	// ==========================================================================
	// Helpers
	function logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
		integer k;
		logic [15:0] r;
		r = c;
		for (k = 7; k >= 0; k--)
			r = {r[14:0], 1'b0} ^ ((r[15] ^ b[k]) ? `WF_CRC_POLY : 16'h0000);
		return r;
	endfunction
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
			n_errors++;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		{reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
		@(posedge clock);
		reg_write <= 1'b0;
		#1;
	endtask
	task rd(input string name, input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		{reg_addr, reg_read} <= {a, 1'b1};
		@(posedge clock);
		reg_read <= 1'b0;
		#1 chk(name, exp, reg_rdata_r);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ==========================================================================
	// Scenarios
	task t_load;
		c02 = crc(crc(16'hffff, 8'h1c), 8'h1e);
		c3 = crc(16'hffff, 8'h1e);
		w = '{32'h8000_0005, 32'h5, 32'h5, 32'h1, 32'h0100_0901, 32'h0e0c_0c0c,
			{c02, c02}, {c3, c02}};
		for (i = 0; i < 3; i++) wr(`WF_PORT_OFS, w[i]);
		rd("write pointer", `WF_CTRL_OFS, 32'h0000_0018);
		wr(`WF_CTRL_OFS, 32'h1);
		rd("rewound pointer", `WF_CTRL_OFS, 32'h0000_0000);
		for (i = 0; i < 8; i++) wr(`WF_PORT_OFS, w[i]);
		w[0] = 32'h5;
		for (i = 0; i < 8; i++) rd("filter word", `WF_PORT_OFS, w[i]);
		$display("t_load done");
	endtask
	task frame(input logic mc, input logic [31:0] exp);
		integer k;
		src_u.send(mc);
		#1;
		for (k = 0; k < 6 && wake_frame_pulse !== 1'b1; k++) begin
			@(posedge clock);
			#1;
		end
		chk("wake pulse", 1, wake_frame_pulse);
		chk("pulse delay", 0, k);
		if (wake_frame_pulse !== 1'b1)
			print_verdict;
		else
			rd("status", `WF_STATUS_OFS, exp);
	endtask
	task t_frames;
		wr(`WF_MASK_OFS, 32'hf);
		frame(1'b0, 32'h9);
		chk("irq set", 1, irq);
		wr(`WF_STATUS_OFS, 32'hf);
		chk("irq cleared", 0, irq);
		frame(1'b1, 32'h2);
		wr(`WF_MASK_OFS, 32'h0);
		chk("irq masked", 0, irq);
		rd("unmapped", 8'h40, 32'h0);
		$display("t_frames done");
	endtask
	initial begin
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		t_load;
		t_frames;
		print_verdict;
	end
endmodule // testbench
bind wake_frame_pattern_filter wake_filter_sva chk_u (.clock(clock), .rst(rst),
	.reg_read(reg_read), .reg_write(reg_write), .reg_rdata_r(reg_rdata_r), .rx_end(rx_end),
	.wake_frame_pulse(wake_frame_pulse), .irq(irq));

//--- tb/wake_filter_sva.sv
/*
 Checker for the port behaviour of the wake-up frame pattern filter.
 Assumes it is bound to the top module from the testbench top file.
*/
`timescale 1ns/1ps
module wake_filter_sva (
	// Watched ports
	input wire        clock,
	input wire        rst,
	input wire        reg_read,
	input wire        reg_write,
	input wire [31:0] reg_rdata_r,
	input wire        rx_end,
	input wire        wake_frame_pulse,
	input wire        irq
);
	// ==========================================================================
	// Assertions
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_rdata_after_read: assert property (reg_rdata_r != 32'h0 |-> $past(reg_read))
		else $error("read data outside its cycle");
	a_write_no_data: assert property (reg_write |=> reg_rdata_r == 32'h0)
		else $error("read data after a write");
	a_pulse_after_end: assert property (wake_frame_pulse |-> $past(rx_end))
		else $error("wake pulse not one cycle after frame end");
	a_pulse_single: assert property (wake_frame_pulse |=> !wake_frame_pulse)
		else $error("wake pulse longer than one cycle");
	a_end_no_pulse: assert property (rx_end |-> !wake_frame_pulse)
		else $error("wake pulse during frame end");
	a_irq_rise_cause: assert property ($rose(irq) |->
		wake_frame_pulse || $past(wake_frame_pulse) || $past(reg_write))
		else $error("interrupt rose without a cause");
	a_irq_fall_cause: assert property ($fell(irq) |-> $past(reg_write))
		else $error("interrupt fell without a write");
	c_pulse: cover property (wake_frame_pulse);
	c_irq_up: cover property ($rose(irq));
	c_irq_down: cover property ($fell(irq));
endmodule // wake_filter_sva

//--- tb/wake_frame_source.sv
/*
 Frame source standing in for the receive path.
 Assumes the testbench calls send and that the clock is the design clock.
*/
`timescale 1ns/1ps
module wake_frame_source (
	// Clock
	input  wire        clock,
	// Frame stream
	output logic       rx_start,
	output logic       rx_valid,
	output logic [7:0] rx_data,
	output logic       rx_end,
	output logic       rx_multicast
);
	initial {rx_start, rx_valid, rx_data, rx_end, rx_multicast} = 12'h0;
	// ==========================================================================
	// Twenty bytes valued 8'h10 plus their index, then the end strobe.
	task send(input logic mc);
		integer i;
		for (i = 0; i < 20; i++) begin
			@(posedge clock);
			rx_start <= (i == 0);
			rx_valid <= 1'b1;
			rx_data <= 8'h10 + i[7:0];
			rx_multicast <= mc;
		end
		@(posedge clock);
		rx_valid <= 1'b0;
		rx_end <= 1'b1;
		rx_data <= ~rx_data;
		@(posedge clock);
		rx_end <= 1'b0;
	endtask
endmodule // wake_frame_source
